// ==== src/eec_exception_entry_control.sv ====
/*
  eec_exception_entry_control: decides when reset, trap and interrupt exception
  handling begins, fetches the handler address from the vector entry and loads it.
  Assumes the core answers a vector read with vecDataValid some cycles later, and
  that peripheral requests and core signals share clk; only the reset pin is async.
*/
// Functional notes
// - Reset outranks every trap or interrupt pending at the same time.
// - Reset handling starts right after the reset pin releases, never while held.
// - Watchdog overflow resets the chip, then runs the same reset handling.
// - Trap instruction starts handling at vector chosen by its two-bit number.
// - Trap is accepted in program execution regardless of interrupt mask.
// - Mask bit set holds off all interrupts except NMI and address break.
// - Accepted interrupts start only after current instruction or handling completes.
// - Each source has fixed two-byte entry; reset at zero, traps from 0x0010.
// - Simultaneous requests are served in fixed priority order.
`default_nettype none
module eec_exception_entry_control
  import eec_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // reset sources
  input wire logic extResetPinN,
  input wire logic wdtOverflow,
  // core status
  input wire logic trapExec,
  input wire logic [1:0] trapNum,
  input wire logic iMask,
  input wire logic instrBoundary,
  // interrupt sources
  input wire logic nmiReq,
  input wire logic brkReq,
  input wire logic [7:0] irqReq,
  // vector fetch
  output logic vecRead,
  output logic [15:0] vecAddr,
  input wire logic vecDataValid,
  input wire logic [15:0] vecData,
  // core control
  output logic chipReset,
  output logic excActive,
  output logic [5:0] excVecNum,
  output logic pcLoad,
  output logic [15:0] pcValue
);
  eec_regs_type q;
  eec_regs_type d;
  logic resetCond;
  logic takeTrap;

  eec_sel_if selIf ();

  // requests into the selector
  assign selIf.trapPend = q.trapPend;
  assign selIf.trapNum = q.trapNum;
  assign selIf.nmiReq = nmiReq;
  assign selIf.brkReq = brkReq;
  assign selIf.irqReq = irqReq;
  assign selIf.iMask = iMask;
  assign selIf.instrBoundary = instrBoundary;

  eec_priority_select uSel (
    .s (selIf.sel)
  );

  // reset pin held or watchdog overflow
  assign resetCond = ~q.pinSync2 | wdtOverflow;
  // the pending trap is the one taken this cycle, so its flag may drop
  assign takeTrap = (q.state == ST_IDLE) && selIf.selValid && q.trapPend &&
                    (selIf.selNum != VEC_NMI);

  // next-state logic
  always_comb begin
    d = q;
    // pin synchroniser; only the second stage is read
    d.pinSync1 = extResetPinN;
    d.pinSync2 = q.pinSync1;
    // strobes fall back low unless set below
    d.vecRead = 1'b0;
    d.pcLoad = 1'b0;
    // a new trap wins over the clear of the one being taken
    if (takeTrap) begin
      d.trapPend = 1'b0;
    end
    if (trapExec) begin
      d.trapPend = 1'b1;
      d.trapNum = trapNum;
    end
    if (resetCond) begin
      d.state = ST_RESET;
      d.chipReset = 1'b1;
      d.trapPend = 1'b0;
      d.excActive = 1'b0;
      if (wdtOverflow) begin
        d.wdtCnt = WDT_HOLD_CYCLES;
      end
    end else begin
      // reset stretch, idle, then wait for the vector word
      case (q.state)
        ST_RESET: begin
          // hold the chip in reset for the watchdog stretch
          if (q.wdtCnt != 3'h0) begin
            d.wdtCnt = q.wdtCnt - 3'h1;
          end else begin
            d.chipReset = 1'b0;
            d.state = ST_WAIT;
            d.vecRead = 1'b1;
            d.vecAddr = {9'h000, VEC_RESET, 1'b0};
            d.excVecNum = VEC_RESET;
            d.excActive = 1'b1;
          end
        end
        ST_IDLE: begin
          // take the winner of the selector
          if (selIf.selValid) begin
            d.state = ST_WAIT;
            d.vecRead = 1'b1;
            d.vecAddr = {9'h000, selIf.selNum, 1'b0};
            d.excVecNum = selIf.selNum;
            d.excActive = 1'b1;
          end
        end
        ST_WAIT: begin
          // the answer word is the handler start address
          if (vecDataValid) begin
            d.pcLoad = 1'b1;
            d.pcValue = vecData;
            d.excActive = 1'b0;
            d.state = ST_IDLE;
          end
        end
        default: begin
          d.state = ST_RESET;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '{pinSync1: 1'b0, pinSync2: 1'b0, state: ST_RESET, wdtCnt: 3'h0,
             trapPend: 1'b0, trapNum: 2'h0, chipReset: 1'b1, vecRead: 1'b0,
             vecAddr: 16'h0000, excVecNum: 6'h00, excActive: 1'b0,
             pcLoad: 1'b0, pcValue: PC_RESET_VALUE};
    end else begin
      q <= d;
    end
  end

  // outputs straight from flip-flops
  assign vecRead = q.vecRead;
  assign vecAddr = q.vecAddr;
  assign chipReset = q.chipReset;
  assign excActive = q.excActive;
  assign excVecNum = q.excVecNum;
  assign pcLoad = q.pcLoad;
  assign pcValue = q.pcValue;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // reset and watchdog
  reset_prio_a: assert property (resetCond |=> q.chipReset && !q.vecRead &&
    q.state == ST_RESET) else $error("reset did not take precedence");
  reset_release_a: assert property (q.state == ST_RESET && q.wdtCnt == 3'h0 &&
    !resetCond |=> q.vecRead && q.vecAddr == 16'h0000 && !q.chipReset)
    else $error("reset handling did not start on release");
  wdt_reset_a: assert property (wdtOverflow |=> q.chipReset [*5])
    else $error("watchdog reset too short");
  // trap, mask and boundary
  trap_vec_a: assert property (q.state == ST_IDLE && q.trapPend && !resetCond &&
    !(nmiReq && instrBoundary) |=> q.vecRead && q.excVecNum == VEC_TRAP_BASE +
    {4'h0, $past(q.trapNum)}) else $error("trap vector wrong");
  trap_unmasked_a: assert property (q.state == ST_IDLE && q.trapPend && iMask &&
    !resetCond |=> q.vecRead) else $error("trap held off by mask");
  irq_mask_a: assert property (q.state == ST_IDLE && iMask && !q.trapPend &&
    !nmiReq && !brkReq |=> !q.vecRead) else $error("masked interrupt taken");
  boundary_wait_a: assert property (q.state == ST_IDLE && !instrBoundary &&
    !q.trapPend |=> !q.vecRead) else $error("interrupt taken mid instruction");
  // vector fetch and priority
  vec_addr_a: assert property (q.vecRead |-> q.vecAddr == {9'h000, q.excVecNum, 1'b0}
    && q.state == ST_WAIT) else $error("vector entry address wrong");
  prio_order_a: assert property (q.state == ST_IDLE && nmiReq && instrBoundary &&
    !resetCond |=> q.excVecNum == VEC_NMI) else $error("priority order wrong");
  pc_load_a: assert property (q.state == ST_WAIT && vecDataValid && !resetCond
    |=> q.pcLoad && q.pcValue == $past(vecData) && q.state == ST_IDLE)
    else $error("handler address not loaded");
  // handling in progress blocks any new entry until the handler address is loaded
  wait_hold_a: assert property (q.state == ST_WAIT && !vecDataValid && !resetCond
    |=> q.state == ST_WAIT && !q.vecRead) else $error("entry taken during handling");
  // the watchdog stretch keeps the vector read back
  wdt_hold_a: assert property (q.state == ST_RESET && q.wdtCnt != 3'h0
    |=> !q.vecRead && q.chipReset) else $error("entry during watchdog stretch");
  // a trap is latched with its number whatever the state
  trap_latch_a: assert property (trapExec && !resetCond |=> q.trapPend &&
    q.trapNum == $past(trapNum)) else $error("trap not latched");
  // reset drops a pending trap
  trap_drop_a: assert property (resetCond |=> !q.trapPend)
    else $error("trap survived reset");
  // address break passes a set mask
  brk_unmasked_a: assert property (q.state == ST_IDLE && brkReq && instrBoundary &&
    iMask && !q.trapPend && !nmiReq && !resetCond |=> q.vecRead &&
    q.excVecNum == VEC_BREAK) else $error("break held off by mask");
  // lowest maskable line wins among unmasked requests
  irq_prio_a: assert property (q.state == ST_IDLE && instrBoundary && !iMask &&
    irqReq[0] && !q.trapPend && !nmiReq && !brkReq && !resetCond |=>
    q.excVecNum == IRQ_VEC[0]) else $error("maskable priority wrong");
  // the load strobe lasts a single cycle
  pc_pulse_a: assert property (q.pcLoad |=> !q.pcLoad)
    else $error("handler load longer than one cycle");

  // scenario covers
  trap_entry_c: cover property (q.vecRead && q.excVecNum == VEC_TRAP_BASE + 6'h03);
  wdt_entry_c: cover property (wdtOverflow ##6 q.vecRead);
  irq_load_c: cover property (q.vecRead && q.excVecNum == IRQ_VEC[0] ##[1:8] q.pcLoad);
  nmi_trap_c: cover property (q.vecRead && q.excVecNum == VEC_NMI && q.trapPend);
  brk_mask_c: cover property (q.vecRead && q.excVecNum == VEC_BREAK && iMask);
endmodule : eec_exception_entry_control
`default_nettype wire

// ==== src/eec_pkg.sv ====
/*
  eec_pkg: constants and types for the exception entry control block.
  Assumes a single 10 MHz clock domain and a 16-bit vector address space.
*/
`default_nettype none
package eec_pkg;
  // vector numbers of each exception source
  localparam logic [5:0] VEC_RESET = 6'h00;
  localparam logic [5:0] VEC_NMI = 6'h07;
  localparam logic [5:0] VEC_TRAP_BASE = 6'h08;
  localparam logic [5:0] VEC_BREAK = 6'h0C;
  // maskable sources in priority order, index 0 highest
  localparam int IRQ_COUNT = 8;
  localparam logic [5:0] IRQ_VEC [IRQ_COUNT] = '{6'h0E, 6'h11, 6'h12, 6'h15,
                                                  6'h16, 6'h17, 6'h18, 6'h19};
  // reset values and counts
  localparam logic [2:0] WDT_HOLD_CYCLES = 3'h4;
  localparam logic [15:0] PC_RESET_VALUE = 16'h0000;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_IDLE,
    ST_WAIT
  } eec_state_type;

  typedef struct packed {
    logic pinSync1;
    logic pinSync2;
    eec_state_type state;
    logic [2:0] wdtCnt;
    logic trapPend;
    logic [1:0] trapNum;
    logic chipReset;
    logic vecRead;
    logic [15:0] vecAddr;
    logic [5:0] excVecNum;
    logic excActive;
    logic pcLoad;
    logic [15:0] pcValue;
  } eec_regs_type;
endpackage : eec_pkg
`default_nettype wire

// ==== src/eec_sel_if.sv ====
/*
  eec_sel_if: requests into the priority selector and its chosen vector.
  Assumes both ends run on the same clock; the signals are combinational.
*/
`default_nettype none
interface eec_sel_if;
  logic trapPend;
  logic [1:0] trapNum;
  logic nmiReq;
  logic brkReq;
  logic [7:0] irqReq;
  logic iMask;
  logic instrBoundary;
  logic selValid;
  logic [5:0] selNum;
  modport sel (
    input trapPend, trapNum, nmiReq, brkReq, irqReq, iMask, instrBoundary,
    output selValid, selNum
  );
  modport ctl (
    output trapPend, trapNum, nmiReq, brkReq, irqReq, iMask, instrBoundary,
    input selValid, selNum
  );
endinterface : eec_sel_if
`default_nettype wire

// ==== src/eec_priority_select.sv ====
/*
  eec_priority_select: picks the highest-priority pending exception other than reset.
  Assumes requests are levels from logic on the same clock.
*/
`default_nettype none
module eec_priority_select
  import eec_pkg::*;
(
  // selector side
  eec_sel_if.sel s
);
  logic [IRQ_COUNT-1:0] irqLive;

  // maskable sources count only unmasked and at an instruction boundary
  genvar g;
  generate
    for (g = 0; g < IRQ_COUNT; g++) begin : gLive
      assign irqLive[g] = s.irqReq[g] & ~s.iMask & s.instrBoundary;
    end
  endgenerate

  // lowest priority first, each higher source overrides
  always_comb begin
    s.selValid = 1'b0;
    s.selNum = VEC_RESET;
    for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
      if (irqLive[i]) begin
        s.selValid = 1'b1;
        s.selNum = IRQ_VEC[i];
      end
    end
    if (s.brkReq && s.instrBoundary) begin
      s.selValid = 1'b1;
      s.selNum = VEC_BREAK;
    end
    if (s.trapPend) begin
      s.selValid = 1'b1;
      s.selNum = VEC_TRAP_BASE + {4'h0, s.trapNum};
    end
    if (s.nmiReq && s.instrBoundary) begin
      s.selValid = 1'b1;
      s.selNum = VEC_NMI;
    end
  end
endmodule : eec_priority_select
`default_nettype wire

// ==== bench/eec_core_model.sv ====
/*
  eec_core_model: core side that answers vector reads with a handler address.
  Assumes vecRead is a one-cycle pulse on clk; delay sets the answer latency.
*/
`default_nettype none
module eec_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // vector fetch
  input wire logic vecRead,
  input wire logic [15:0] vecAddr,
  input wire logic [2:0] delay,
  output logic vecDataValid,
  output logic [15:0] vecData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] addrQ;
  logic [2:0] cntQ;
  logic busyQ;
  // handler word follows the entry address; outside valid the bus shows its inverse
  assign vecData = vecDataValid ? (16'hC000 | addrQ) : ~(16'hC000 | addrQ);
  // one-cycle answer after delay plus one idle cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busyQ <= 1'b0;
      cntQ <= 3'h0;
      addrQ <= 16'h0000;
      vecDataValid <= 1'b0;
    end else begin
      vecDataValid <= 1'b0;
      if (vecRead) begin
        busyQ <= 1'b1;
        cntQ <= delay;
        addrQ <= vecAddr;
      end else if (busyQ && cntQ == 3'h0) begin
        vecDataValid <= 1'b1;
        busyQ <= 1'b0;
      end else if (busyQ) begin
        cntQ <= cntQ - 3'h1;
      end
    end
  end
endmodule : eec_core_model
`default_nettype wire

// ==== bench/test_exception_entry_control.sv ====
/*
  test_exception_entry_control: self-checking bench for exception entry.
  Assumes the core model answers vector reads; inputs change at falling edges.
*/
`default_nettype none
module test_exception_entry_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, pinN, wdt, trapExec, iMask, bnd, nmi, brk, vecRead, vecDataValid;
  logic chipReset, excActive, pcLoad;
  logic [1:0] trapNum;
  logic [7:0] irq;
  logic [15:0] vecAddr, vecData, pcValue;
  logic [5:0] excVecNum;
  logic [2:0] delay;
  int nFail, nCompared;

  eec_exception_entry_control dut (.clk(clk), .rst(rst), .extResetPinN(pinN),
    .wdtOverflow(wdt), .trapExec(trapExec), .trapNum(trapNum), .iMask(iMask),
    .instrBoundary(bnd), .nmiReq(nmi), .brkReq(brk), .irqReq(irq), .vecRead(vecRead),
    .vecAddr(vecAddr), .vecDataValid(vecDataValid), .vecData(vecData),
    .chipReset(chipReset), .excActive(excActive), .excVecNum(excVecNum),
    .pcLoad(pcLoad), .pcValue(pcValue));
  eec_core_model core (.clk(clk), .rst(rst), .vecRead(vecRead), .vecAddr(vecAddr),
    .delay(delay), .vecDataValid(vecDataValid), .vecData(vecData));

  task automatic chk(input logic ok, input string msg);
    nCompared++;
    if (ok !== 1'b1) begin
      nFail++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk
  // one whole entry: vector read at num*2, then handler load
  task automatic entry(input logic [5:0] num);
    logic [15:0] a;
    a = {9'h000, num, 1'b0};
    for (int i = 0; i < 40 && vecRead !== 1'b1; i++) @(negedge clk);
    chk(vecRead === 1'b1 && excVecNum === num && vecAddr === a && excActive === 1'b1 &&
        chipReset === 1'b0, "entry");
    for (int i = 0; i < 40 && pcLoad !== 1'b1; i++) @(negedge clk);
    chk(pcLoad === 1'b1 && pcValue === (16'hC000 | a) && excActive === 1'b0, "handler load");
  endtask : entry
  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge clk);
      chk(vecRead === 1'b0, "early entry");
    end
  endtask : quiet
  task automatic giveVerdict();
    $display("compared %0d failed %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : giveVerdict

  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // held pin keeps the chip in reset; entry comes on the third edge after release
  task automatic pinResetTest();
    quiet(10);
    chk(chipReset === 1'b1, "pin reset not held");
    pinN = 1'b1;
    quiet(2);
    @(negedge clk);
    chk(vecRead === 1'b1, "reset entry late");
    entry(6'h00);
    $display("pin reset test done");
  endtask : pinResetTest
  // overflow stretches the chip reset, then runs the same entry as the pin
  task automatic watchdogTest();
    wdt = 1'b1;
    @(negedge clk);
    wdt = 1'b0;
    repeat (int'(eec_pkg::WDT_HOLD_CYCLES) + 1) begin
      chk(chipReset === 1'b1 && vecRead === 1'b0, "watchdog reset too short");
      @(negedge clk);
    end
    chk(vecRead === 1'b1, "watchdog entry late");
    entry(6'h00);
    $display("watchdog test done");
  endtask : watchdogTest
  // every trap number under a set mask, with a growing answer latency
  task automatic trapTest();
    iMask = 1'b1;
    for (int n = 0; n < 4; n++) begin
      trapNum = n[1:0];
      delay = n[2:0];
      trapExec = 1'b1;
      @(negedge clk);
      trapExec = 1'b0;
      entry(6'h08 + n[5:0]);
    end
    $display("trap test done");
  endtask : trapTest
  // mask holds off maskable lines only; no entry away from a boundary
  task automatic maskTest();
    iMask = 1'b1;
    bnd = 1'b1;
    irq = 8'hFF;
    quiet(8);
    nmi = 1'b1;
    entry(6'h07);
    nmi = 1'b0;
    brk = 1'b1;
    entry(6'h0C);
    brk = 1'b0;
    irq = 8'h08;
    iMask = 1'b0;
    bnd = 1'b0;
    quiet(8);
    bnd = 1'b1;
    entry(6'h15);
    $display("mask and boundary test done");
  endtask : maskTest
  // all sources at once are served from the highest down
  task automatic priorityTest();
    nmi = 1'b1;
    brk = 1'b1;
    irq = 8'h81;
    trapNum = 2'h1;
    trapExec = 1'b1;
    @(negedge clk);
    trapExec = 1'b0;
    entry(6'h07);
    nmi = 1'b0;
    entry(6'h09);
    entry(6'h0C);
    brk = 1'b0;
    entry(6'h0E);
    irq = 8'h80;
    entry(6'h19);
    irq = 8'h00;
    $display("priority test done");
  endtask : priorityTest
  // reset wins over a pending interrupt and drops a trap taken while held
  task automatic resetPriorityTest();
    pinN = 1'b0;
    quiet(3);
    nmi = 1'b1;
    trapNum = 2'h2;
    trapExec = 1'b1;
    quiet(1);
    trapExec = 1'b0;
    quiet(6);
    chk(chipReset === 1'b1, "reset over nmi");
    pinN = 1'b1;
    entry(6'h00);
    entry(6'h07);
    nmi = 1'b0;
    quiet(4);
    $display("reset priority test done");
  endtask : resetPriorityTest

  // main sequence
  initial begin
    {rst, pinN, wdt, trapExec, iMask, bnd, nmi, brk} = 8'h80;
    trapNum = 2'h0;
    irq = 8'h00;
    delay = 3'h0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    pinResetTest();
    watchdogTest();
    trapTest();
    maskTest();
    priorityTest();
    resetPriorityTest();
    giveVerdict();
  end
  // watchdog against a hang: the whole run needs under two hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    nFail++;
    giveVerdict();
  end
endmodule : test_exception_entry_control
`default_nettype wire
